// >>> hdl/uart_rx_pkg.sv
// Purpose: shared constants for the uart receiver status block
// Assumes: 125 MHz instruction clock drives the baud generator
// Notes: status and mode bit positions match the software view
package uart_rx_pkg;
   localparam int STAT_DATA_AVAIL = 0;
   localparam int STAT_OVERRUN = 1;
   localparam int STAT_FRAMING = 2;
   localparam int STAT_PARITY = 3;
   localparam int STAT_IDLE = 4;
   localparam int STAT_ADDR_DET = 5;
   localparam int MODE_STOP_SEL = 0;
   localparam int MODE_DATA_PARITY_SELECT_LO = 1;
   localparam int MODE_DATA_PARITY_SELECT_HI = 2;
   localparam logic [1:0] PD_8N = 2'h0;
   localparam logic [1:0] PD_8E = 2'h1;
   localparam logic [1:0] PD_8O = 2'h2;
   localparam logic [1:0] PD_9N = 2'h3;
   localparam logic [15:0] BAUD_DIV_RESET = 16'h0000;
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
   localparam logic [3:0] MID_SAMPLE = 4'h7;
   localparam logic [4:0] BREAK_BIT_TIMES = 5'h0d;
   localparam int FIFO_DEPTH = 8;
   localparam int WORD_W = 11;
endpackage

// >>> hdl/uart_rx_errors.sv
// Purpose: uart receiver with error flags, break, address detect, loopback and baud generator
// Assumes: software drives mode and control ports from the same clock
// Notes: fifo stores data, ninth bit, framing and parity error per character
// Behaviour
// - overrun when fifo full at stop bit
// - overrun blocks shifting until software clears
// - zero at any stop bit sets framing
// - framing flag stored per character, reset clears
// - parity checked only in parity modes
// - parity flag stored per character, reset clears
// - idle low from start to last stop sample
// - bit count from data/parity and stop select
// - long break loads zero word with framing
// - after break wait for high before start
// - idle reads one right after break load
// - ninth bit marks address in detect mode
// - address mode in 9 bit mode interrupts only when the ninth bit is set
// - loopback feeds transmit into receiver
// - sixteen bit read/write baud divisor
// - bit rate is clock over 16(div+1)
// - data read pops fifo, flags follow head
// - 8 bit even/odd/none or 9 bit
`timescale 1ns/1ps

module uart_rx_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp, rp, next_wp, next_rp;
   logic [AW:0] next_count;
   logic push, pop;
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_comb begin
      next_wp = push ? wp + 1'b1 : wp;
      next_rp = pop ? rp + 1'b1 : rp;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp <= '0;
         rp <= '0;
         count <= '0;
      end else if (ce) begin
         wp <= next_wp;
         rp <= next_rp;
         count <= next_count;
      end
   end
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wp] <= in_data;
      end
   end
endmodule // uart_rx_fifo

module uart_rx_errors #(
   parameter int DEPTH = uart_rx_pkg::FIFO_DEPTH
) (
   input wire logic I_CLOCK,
   input wire logic I_SYS_RST,
   input wire logic i_enable,
   input wire logic i_rx_pin,
   input wire logic i_tx_internal,
   input wire logic [2:0] i_uart_mode_reg,
   input wire logic i_address_detect_enable,
   input wire logic [1:0] i_rx_irq_select,
   input wire logic i_loopback_enable,
   input wire logic i_baud_wr,
   input wire logic [15:0] i_baud_wdata,
   input wire logic i_overrun_clear,
   input wire logic i_rx_data_read,
   output logic o_tx_pin,
   output logic [15:0] o_baud_divisor_reg,
   output logic [5:0] o_uart_status_reg,
   output logic [8:0] o_rx_data_reg,
   output logic o_rx_irq,
   output logic o_tick16
);
   initial begin
      if (DEPTH < 4) $error("receive fifo must hold at least four words");
   end

   // ------------------------------------------------------------
   // baud generator
   // ------------------------------------------------------------
   logic [15:0] baud_div, next_baud_div, baud_cnt, next_baud_cnt;
   logic tick, next_tick;
   always_comb begin
      next_baud_div = i_baud_wr ? i_baud_wdata : baud_div;
      next_tick = 1'b0;
      // reload on a write so a new rate takes effect at once
      if (i_baud_wr || baud_cnt == 16'h0000) begin
         next_baud_cnt = i_baud_wr ? i_baud_wdata : baud_div;
         next_tick = !i_baud_wr;
      end else begin
         next_baud_cnt = baud_cnt - 16'h0001;
      end
   end
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         baud_div <= uart_rx_pkg::BAUD_DIV_RESET;
         baud_cnt <= uart_rx_pkg::BAUD_DIV_RESET;
         tick <= 1'b0;
      end else if (i_enable) begin
         baud_div <= next_baud_div;
         baud_cnt <= next_baud_cnt;
         tick <= next_tick;
      end
   end

   // ------------------------------------------------------------
   // input sync and loopback select
   // ------------------------------------------------------------
   logic [2:0] pin_sync, next_pin_sync;
   logic line, next_line, rx_in;
   always_comb begin
      next_pin_sync = {pin_sync[1:0], i_rx_pin};
      next_line = (pin_sync[2] == pin_sync[1]) ? pin_sync[2] : line;
   end
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         pin_sync <= 3'h7;
         line <= 1'b1;
         o_tx_pin <= 1'b1;
      end else if (i_enable) begin
         pin_sync <= next_pin_sync;
         line <= next_line;
         o_tx_pin <= i_tx_internal;
      end
   end
   assign rx_in = i_loopback_enable ? o_tx_pin : line;

   // ------------------------------------------------------------
   // receive state machine
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_START = 3'h1, S_DATA = 3'h2, S_STOP = 3'h3,
      S_WAIT_HIGH = 3'h4, S_HOLD = 3'h5
   } rx_state_t;
   rx_state_t state, next_state;
   logic [3:0] phase, next_phase, nbits, next_nbits, frame_bits;
   logic [8:0] rx_shift_reg, next_rx_shift_reg;
   logic stop2, next_stop2, framing_error_flag_acc, next_framing_error_flag_acc, idle, next_idle;
   logic overrun_flag, next_overrun_flag, push_word, ovr_event;
   logic [4:0] low_bits, next_low_bits;
   logic [1:0] pd;
   logic fifo_ready, fifo_valid, par_bad, parity_mode, all_zero;
   logic [uart_rx_pkg::WORD_W-1:0] fifo_out, push_data;
   logic [$clog2(DEPTH):0] fifo_count;

   function automatic logic [3:0] data_bits(input logic [1:0] sel);
      data_bits = (sel == uart_rx_pkg::PD_9N) ? 4'h9 : 4'h8;
   endfunction

   assign pd = i_uart_mode_reg[uart_rx_pkg::MODE_DATA_PARITY_SELECT_HI:uart_rx_pkg::MODE_DATA_PARITY_SELECT_LO];
   assign parity_mode = (pd == uart_rx_pkg::PD_8E) || (pd == uart_rx_pkg::PD_8O);
   assign frame_bits = data_bits(pd) + (parity_mode ? 4'h1 : 4'h0);
   // parity only in even or odd mode
   assign par_bad = parity_mode &&
      ((^rx_shift_reg) != (pd == uart_rx_pkg::PD_8O));
   assign all_zero = (rx_shift_reg == 9'h000) && (low_bits >= uart_rx_pkg::BREAK_BIT_TIMES);

   always_comb begin
      next_state = state;
      next_phase = phase;
      next_nbits = nbits;
      next_rx_shift_reg = rx_shift_reg;
      next_stop2 = stop2;
      next_framing_error_flag_acc = framing_error_flag_acc;
      next_idle = idle;
      next_low_bits = low_bits;
      push_word = 1'b0;
      ovr_event = 1'b0;
      push_data = '0;
      next_overrun_flag = overrun_flag && !i_overrun_clear;
      case (state)
         S_IDLE: begin
            if (!rx_in && !overrun_flag) begin
               next_state = S_START;
               next_phase = 4'h0;
               next_idle = 1'b0;
               next_low_bits = 5'h00;
            end
         end
         default: begin
            if (tick) begin
               next_phase = phase + 4'h1;
               if (phase == uart_rx_pkg::MID_SAMPLE) begin
                  case (state)
                     S_START: begin
                        if (rx_in) begin
                           next_state = S_IDLE;
                           next_idle = 1'b1;
                        end else begin
                           next_state = S_DATA;
                           next_nbits = 4'h0;
                           next_rx_shift_reg = 9'h000;
                           next_low_bits = 5'h01;
                        end
                     end
                     S_DATA: begin
                        // frame bits land lsb first; parity kept in top slot
                        next_rx_shift_reg[nbits] = rx_in;
                        if (!rx_in && low_bits == {1'b0, nbits} + 5'h01) begin
                           next_low_bits = low_bits + 5'h01;
                        end
                        next_nbits = nbits + 4'h1;
                        if (nbits + 4'h1 == frame_bits) begin
                           next_state = S_STOP;
                           next_stop2 = i_uart_mode_reg[uart_rx_pkg::MODE_STOP_SEL];
                           next_framing_error_flag_acc = 1'b0;
                        end
                     end
                     S_STOP: begin
                        next_framing_error_flag_acc = framing_error_flag_acc | !rx_in;
                        if (!rx_in && low_bits == {1'b0, frame_bits} + 5'h01) begin
                           next_low_bits = low_bits + 5'h01;
                        end
                        if (stop2) begin
                           next_stop2 = 1'b0;
                        end else begin
                           next_idle = 1'b1;
                           if (!fifo_ready) begin
                              ovr_event = 1'b1;
                              next_overrun_flag = 1'b1;
                              next_state = S_HOLD;
                           end else begin
                              push_word = 1'b1;
                              push_data = {framing_error_flag_acc | !rx_in, par_bad, rx_shift_reg};
                              // low line after a bad stop is not a start
                              next_state = (framing_error_flag_acc | !rx_in) ? S_WAIT_HIGH : S_IDLE;
                           end
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
            if (state == S_WAIT_HIGH && rx_in) begin
               next_state = S_IDLE;
            end
            if (state == S_HOLD && !overrun_flag) begin
               next_state = S_IDLE;
            end
            if (state == S_WAIT_HIGH || state == S_HOLD) begin
               next_phase = 4'h0;
            end
         end
      endcase
   end
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         state <= S_IDLE;
         phase <= 4'h0;
         nbits <= 4'h0;
         rx_shift_reg <= 9'h000;
         stop2 <= 1'b0;
         framing_error_flag_acc <= 1'b0;
         idle <= 1'b1;
         low_bits <= 5'h00;
         overrun_flag <= 1'b0;
      end else if (i_enable) begin
         state <= next_state;
         phase <= next_phase;
         nbits <= next_nbits;
         rx_shift_reg <= next_rx_shift_reg;
         stop2 <= next_stop2;
         framing_error_flag_acc <= next_framing_error_flag_acc;
         idle <= next_idle;
         low_bits <= next_low_bits;
         overrun_flag <= next_overrun_flag; // set wins over clear
      end
   end

   // ------------------------------------------------------------
   // receive fifo and software view
   // ------------------------------------------------------------
   uart_rx_fifo #(.WIDTH(uart_rx_pkg::WORD_W), .DEPTH(DEPTH)) rx_fifo (
      .clk(I_CLOCK),
      .rst(I_SYS_RST),
      .ce(i_enable),
      .in_valid(push_word),
      .in_ready(fifo_ready),
      .in_data(push_data),
      .out_valid(fifo_valid),
      .out_ready(i_rx_data_read),
      .out_data(fifo_out),
      .count(fifo_count)
   );

   logic irq_hit;
   always_comb begin
      irq_hit = 1'b0;
      if (push_word) begin
         if (i_address_detect_enable && pd == uart_rx_pkg::PD_9N) begin
            irq_hit = rx_shift_reg[8];
         end else begin
            case (i_rx_irq_select)
               2'h2: irq_hit = (fifo_count == ($clog2(DEPTH)+1)'(2));
               2'h3: irq_hit = (fifo_count == ($clog2(DEPTH)+1)'(3));
               default: irq_hit = 1'b1;
            endcase
         end
      end
   end
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         o_uart_status_reg <= 6'h10;
         o_rx_data_reg <= 9'h000;
         o_baud_divisor_reg <= uart_rx_pkg::BAUD_DIV_RESET;
         o_rx_irq <= 1'b0;
         o_tick16 <= 1'b0;
      end else if (i_enable) begin
         o_uart_status_reg[uart_rx_pkg::STAT_DATA_AVAIL] <= fifo_valid;
         o_uart_status_reg[uart_rx_pkg::STAT_OVERRUN] <= overrun_flag;
         o_uart_status_reg[uart_rx_pkg::STAT_FRAMING] <= fifo_valid & fifo_out[10];
         o_uart_status_reg[uart_rx_pkg::STAT_PARITY] <= fifo_valid & fifo_out[9];
         o_uart_status_reg[uart_rx_pkg::STAT_IDLE] <= idle;
         o_uart_status_reg[uart_rx_pkg::STAT_ADDR_DET] <= i_address_detect_enable;
         o_rx_data_reg <= fifo_out[8:0];
         o_baud_divisor_reg <= baud_div;
         o_rx_irq <= irq_hit;
         o_tick16 <= tick;
      end
   end

   // break word: data bits all zero and stop low, so push_data is zeros plus framing, plus parity in odd mode
   logic unused_zero;
   assign unused_zero = all_zero;

   ovr_needs_full_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      ovr_event |-> !fifo_ready) else $error("overrun without full fifo");
   ovr_blocks_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      overrun_flag && state == S_IDLE |=> state == S_IDLE || !$past(overrun_flag) ||
      $past(i_overrun_clear)) else $error("shift started during overrun");
   framing_error_flag_push_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      push_word && !rx_in && !stop2 |-> push_data[10]) else $error("framing lost");
   parity_error_flag_off_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      push_word && !parity_mode |-> !push_data[9]) else $error("parity in none mode");
   idle_active_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      state == S_DATA |-> !idle) else $error("idle during data");
   break_wait_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST || !i_enable)
      state == S_WAIT_HIGH && !rx_in |=> state == S_WAIT_HIGH) else $error("break as start");
   break_idle_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
      state == S_WAIT_HIGH |-> idle) else $error("idle low after break");
   addr_irq_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST || !i_enable)
      push_word && i_address_detect_enable && pd == uart_rx_pkg::PD_9N && rx_shift_reg[8]
      |=> o_rx_irq) else $error("address irq missing");
   baud_tick_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST || !i_enable)
      tick && baud_div == 16'h0000 && !i_baud_wr |=> !i_enable || tick)
      else $error("divisor zero not every cycle");
endmodule // uart_rx_errors

// >>> verif/uart_line_model.sv
// Purpose: remote serial node that drives one line into the receiver
// Assumes: bit time is given in clock cycles
// Notes: line idles high and returns high after every frame
`timescale 1ns/1ps

module uart_line_model (
   input wire logic clk,
   output logic line
);
   initial line = 1'b1;

   // level is changed just after a rising edge and held for cyc cycles
   task automatic hold(input logic lvl, input int cyc);
      @(posedge clk);
      #1 line = lvl;
      repeat (cyc - 1) @(posedge clk);
   endtask

   // bit 0 is the start bit, lsb first, stop bits last
   task automatic send(input logic [12:0] bits, input int n, input int bt);
      for (int i = 0; i < n; i++) begin
         hold(bits[i], bt);
      end
      hold(1'b1, 1);
   endtask
endmodule // uart_line_model

// >>> verif/uart_rx_errors_test.sv
// Purpose: self-checking bench for uart_rx_errors
// Assumes: divisor 1 gives 32 clocks per bit on the line
// Notes: outputs are judged a few cycles after each frame ends
`timescale 1ns/1ps

module uart_rx_errors_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   logic rx_line;
   logic tx_line;
   logic [2:0] mode = 3'h0;
   logic address_detect_enable = 1'b0;
   logic [1:0] isel = 2'h0;
   logic lpb = 1'b0;
   logic wr = 1'b0;
   logic [15:0] wdata = 16'h0000;
   logic oclr = 1'b0;
   logic rd = 1'b0;
   logic tx_pin;
   logic irq;
   logic tick;
   logic [15:0] div;
   logic [5:0] st;
   logic [8:0] dat;
   int fails = 0;
   int checks = 0;
   int irqs = 0;
   int bt = 32;

   uart_rx_errors u_uart_rx_errors (.I_CLOCK(clk), .I_SYS_RST(rst), .i_enable(en),
      .i_rx_pin(rx_line), .i_tx_internal(tx_line), .i_uart_mode_reg(mode),
      .i_address_detect_enable(address_detect_enable), .i_rx_irq_select(isel), .i_loopback_enable(lpb),
      .i_baud_wr(wr), .i_baud_wdata(wdata), .i_overrun_clear(oclr),
      .i_rx_data_read(rd), .o_tx_pin(tx_pin), .o_baud_divisor_reg(div),
      .o_uart_status_reg(st), .o_rx_data_reg(dat), .o_rx_irq(irq), .o_tick16(tick));
   uart_line_model u_line_rx (.clk(clk), .line(rx_line));
   uart_line_model u_line_tx (.clk(clk), .line(tx_line));

   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (irq === 1'b1) irqs++;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pop();
      cyc(1);
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      cyc(2);
   endtask
   task automatic wr_div(input logic [15:0] v);
      cyc(1);
      wr = 1'b1;
      wdata = v;
      cyc(1);
      wr = 1'b0;
      cyc(2);
   endtask
   // the 9th data bit doubles as the parity bit in parity modes
   task automatic tx_word(input logic [8:0] d, input logic bad);
      logic [12:0] b;
      int n;
      n = (mode[2:1] == uart_rx_pkg::PD_8N ? 10 : 11) + int'(mode[0]);
      b = (mode[2:1] == uart_rx_pkg::PD_8N) ? {4'hf, d[7:0], 1'b0} : {3'h7, d, 1'b0};
      if (bad) b[n-1] = 1'b0;
      u_line_rx.send(b, n, bt);
      cyc(8);
   endtask
   task automatic done(input string m);
      $display("test %s finished", m);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_baud();
      logic [15:0] dv [4] = '{16'hffff, 16'h0000, 16'h0003, 16'h0001};
      int n;
      foreach (dv[k]) begin
         wr_div(dv[k]);
         chk(div, dv[k], "divisor readback");
         if (dv[k] < 16'h0010) begin
            // tick is read settled, one step after the edge that launches it
            n = 0;
            while (tick !== 1'b1 && n < 99) begin
               cyc(1);
               n++;
            end
            n = 0;
            do begin
               cyc(1);
               n++;
            end while (tick !== 1'b1 && n < 99);
            chk(16'(n), dv[k] + 16'h0001, "tick spacing");
         end
      end
      // a low clock enable must freeze the divisor against a write
      en = 1'b0;
      wr_div(16'h0005);
      chk(div, 16'h0001, "frozen divisor");
      en = 1'b1;
      cyc(2);
      done("baud");
   endtask

   task automatic t_plain();
      irqs = 0;
      fork
         tx_word(9'h0a5, 1'b0);
         begin
            cyc(5 * bt);
            chk(st[uart_rx_pkg::STAT_IDLE], 1'b0, "idle in frame");
         end
      join
      chk(st, 16'h0011, "status after byte");
      chk(dat[7:0], 16'h00a5, "byte value");
      chk(16'(irqs), 16'h0001, "one irq");
      pop();
      chk(st, 16'h0010, "empty after read");
      done("plain");
   endtask

   task automatic t_parity();
      logic p;
      for (int pd = 1; pd < 4; pd++) begin
         mode = {2'(pd), 1'b0};
         p = ^8'h35 ^ (pd == 2);
         tx_word({p, 8'h35}, 1'b0);
         tx_word({~p, 8'h35}, 1'b0);
         chk(st[uart_rx_pkg::STAT_PARITY], 1'b0, "good parity");
         pop();
         chk(st[uart_rx_pkg::STAT_PARITY], pd != 3, "bad parity");
         chk(dat[7:0], 16'h0035, "parity data");
         pop();
      end
      mode = 3'h0;
      done("parity");
   endtask

   task automatic t_frame();
      mode = 3'h1;
      tx_word(9'h011, 1'b0);
      tx_word(9'h022, 1'b1);
      chk(st[uart_rx_pkg::STAT_FRAMING], 1'b0, "two stops good");
      pop();
      chk(st[uart_rx_pkg::STAT_FRAMING], 1'b1, "second stop low");
      chk(dat[7:0], 16'h0022, "framed data");
      mode = 3'h0;
      tx_word(9'h033, 1'b1);
      cyc(1);
      rst = 1'b1;
      cyc(2);
      chk(st, 16'h0010, "reset clears flags");
      rst = 1'b0;
      wr_div(16'h0001);
      done("frame");
   endtask

   task automatic t_break();
      irqs = 0;
      fork
         u_line_rx.hold(1'b0, 20 * bt);
         begin
            cyc(14 * bt);
            chk(st, 16'h0015, "break loaded");
            chk(dat, 16'h0000, "break zeros");
            chk(16'(irqs), 16'h0001, "break irq");
         end
      join
      u_line_rx.hold(1'b1, 2 * bt);
      tx_word(9'h03c, 1'b0);
      pop();
      chk(dat[7:0], 16'h003c, "after break");
      chk(st[uart_rx_pkg::STAT_FRAMING], 1'b0, "after break framing_error_flag");
      pop();
      chk(st[uart_rx_pkg::STAT_DATA_AVAIL], 1'b0, "no extra word");
      done("break");
   endtask

   task automatic t_overrun();
      for (int i = 0; i < 8; i++) tx_word(9'(i), 1'b0);
      chk(st[uart_rx_pkg::STAT_OVERRUN], 1'b0, "full, no overrun");
      tx_word(9'h0aa, 1'b0);
      chk(st[uart_rx_pkg::STAT_OVERRUN], 1'b1, "overrun");
      tx_word(9'h055, 1'b0);
      pop();
      chk(st[uart_rx_pkg::STAT_OVERRUN], 1'b1, "overrun holds");
      cyc(1);
      oclr = 1'b1;
      cyc(1);
      oclr = 1'b0;
      cyc(2);
      chk(st[uart_rx_pkg::STAT_OVERRUN], 1'b0, "overrun cleared");
      for (int i = 1; i < 8; i++) begin
         chk(dat, 16'(i), "kept word");
         pop();
      end
      for (int i = 0; i < 4 && st[uart_rx_pkg::STAT_DATA_AVAIL] === 1'b1; i++) pop();
      done("overrun");
   endtask

   task automatic t_addr();
      mode = 3'h6;
      address_detect_enable = 1'b1;
      isel = 2'h3;
      cyc(2);
      irqs = 0;
      tx_word(9'h1a5, 1'b0);
      chk(16'(irqs), 16'h0001, "address irq");
      tx_word(9'h0a5, 1'b0);
      chk(16'(irqs), 16'h0001, "data no irq");
      chk(dat, 16'h01a5, "address word");
      chk(st[uart_rx_pkg::STAT_ADDR_DET], 1'b1, "detect echo");
      pop();
      pop();
      {mode, address_detect_enable, isel} = 6'h00;
      done("addr");
   endtask

   task automatic t_loop();
      lpb = 1'b1;
      u_line_rx.hold(1'b0, 1);
      fork
         u_line_tx.send({4'hf, 8'h96, 1'b0}, 10, bt);
         begin
            cyc(bt / 2);
            chk(tx_pin, 1'b0, "tx pin drives");
         end
      join
      cyc(8);
      chk(st, 16'h0011, "loop status");
      chk(dat[7:0], 16'h0096, "loop data");
      pop();
      u_line_rx.hold(1'b1, 2);
      lpb = 1'b0;
      done("loop");
   endtask

   task automatic print_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      cyc(3);
      chk(st, 16'h0010, "reset status");
      chk({dat, tx_pin}, 16'h0001, "reset data and pin");
      chk(div, 16'h0000, "reset divisor");
      cyc(1);
      rst = 1'b0;
      t_baud();
      t_plain();
      t_parity();
      t_frame();
      t_break();
      t_overrun();
      t_addr();
      t_loop();
      print_verdict();
   end

   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      print_verdict();
   end
endmodule // uart_rx_errors_test
